/* File: include/lgs_pkg.sv */
// What this block does
// - 224-bit shift register, 218-bit data latch.
// - Write command 25h copies low bits on latch pulse once the edge counter is still.
// - Any other command leaves the latch unchanged.
// - Each serial clock rise shifts input into bit zero.
// - Serial output always shows shift register top bit.
// - Shift register has no reset value.
// - Reset sets only the blanking bit, outputs off.
// - PWM, brightness and function outputs use latch values, never the shift register.
// - FFFFh: 512 clocks, 511 in period 128.
// - FFFEh: 511 clocks in periods 64 and 128.
// - FF01h: 512 in period 1, else 511.
// - FF00h: 511 clocks in every period.
// - FEFFh: 511 clocks, 510 in period 128.
// - Extra clocks go to periods in bit-reversed order.
// - Gray values are consecutive 16-bit latch slices.
package lgs_pkg;
  localparam int SHIFT_W = 224;
  localparam int LATCH_W = 218;
  localparam int CMD_W = 6;
  localparam logic [CMD_W-1:0] WRITE_CMD = 6'h25;
  localparam int BLANK_BIT = 213;
  localparam int GRAY_W = 16;
  localparam int CH_N = 12;
  localparam int BC_LSB = 192;
  localparam int BC_W = 21;
  localparam int FC_LSB = 213;
  localparam int FC_W = 5;
  localparam int POS_W = 9;
  localparam int PER_W = 7;
  localparam int CNT_W = 16;
  localparam int ON_W = 10;
  localparam logic [POS_W-1:0] ADJ_LO = 9'h1fd;
  localparam logic [POS_W-1:0] ADJ_HI = 9'h1fe;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] CTRL_OFF = 4'h0;
  localparam logic [ADDR_W-1:0] STATUS_OFF = 4'h4;
  localparam int CTRL_EN_BIT = 0;
  localparam int STAT_BLANK_BIT = 0;
  localparam int STAT_QUIET_BIT = 1;
  localparam int STAT_PER_LSB = 8;
  localparam logic CTRL_EN_RESET = 1'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] GRAY_RESET = 2'h0;
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0;

  typedef struct packed {
    logic               rst1;
    logic               rst2;
    logic [1:0]         gray;
    logic [SHIFT_W-1:0] shift;
  } lgs_link_type;

  typedef struct packed {
    logic [1:0]         gs1;
    logic [1:0]         gs2;
    logic [1:0]         gprev;
    logic [SHIFT_W-1:0] sh1;
    logic [SHIFT_W-1:0] sh2;
    logic [LATCH_W-1:0] latch;
    logic [CNT_W-1:0]   cnt;
    logic [CH_N-1:0]    pwm;
    logic               en;
    logic               aw_have;
    logic [ADDR_W-1:0]  awaddr;
    logic               w_have;
    logic [DATA_W-1:0]  wdata;
    logic [3:0]         wstrb;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               rvalid;
    logic [DATA_W-1:0]  rdata;
    logic [1:0]         rresp;
  } lgs_core_type;
endpackage

/* File: hdl/lgs_top.sv */
`timescale 1ns/1ps
`default_nettype none
module lgs_top (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic [lgs_pkg::ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [lgs_pkg::DATA_W-1:0]    s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [lgs_pkg::ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [lgs_pkg::DATA_W-1:0]         s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  input  wire logic                          serial_shift_clock,
  input  wire logic                          serial_in_pin,
  output logic                               serial_out_pin,
  input  wire logic                          latch_pulse,
  output logic [lgs_pkg::CH_N-1:0]           pwm_out,
  output logic [lgs_pkg::BC_W-1:0]           color_group_brightness,
  output logic [lgs_pkg::FC_W-1:0]           function_settings
);
  import lgs_pkg::*;

  lgs_link_type l_q;
  lgs_link_type l_d;
  lgs_core_type c_q;
  lgs_core_type c_d;
  logic         quiet;
  logic         cmd_ok;
  logic         aw_hs;
  logic         w_hs;
  logic         ar_hs;

  function automatic logic [PER_W-1:0] bitrev(input logic [PER_W-1:0] p);
    logic [PER_W-1:0] r;
    r = '0;
    for (int i = 0; i < PER_W; i++) begin
      r[i] = p[PER_W-1-i];
    end
    return r;
  endfunction

  // Near full scale the on-time is one clock longer than the plain split,
  // which keeps the documented FEFFh to FF01h steps at the cost of monotony.
  function automatic logic [ON_W-1:0] on_len(input logic [GRAY_W-1:0] g,
                                             input logic [PER_W-1:0] per);
    logic [POS_W-1:0] base;
    logic [PER_W-1:0] frac;
    logic             extra;
    logic             adj;
    base  = g[GRAY_W-1:PER_W];
    frac  = g[PER_W-1:0];
    extra = bitrev(per) < frac;
    adj   = (base == ADJ_LO) || (base == ADJ_HI);
    return {1'b0, base} + {{(ON_W-1){1'b0}}, extra} + {{(ON_W-1){1'b0}}, adj};
  endfunction

  // Link domain: only the reset synchroniser and edge counter are reset.
  always_comb begin
    l_d      = l_q;
    l_d.rst1 = aresetn;
    l_d.rst2 = l_q.rst1;
    l_d.gray = l_q.rst2 ? {l_q.gray[0], ~l_q.gray[1]} : GRAY_RESET;
    l_d.shift = {l_q.shift[SHIFT_W-2:0], serial_in_pin};
  end

  always_ff @(posedge serial_shift_clock) begin
    l_q <= l_d;
  end

  assign serial_out_pin = l_q.shift[SHIFT_W-1];

  // The shift register is copied as a quasi-static word once the edge
  // counter has stopped moving, so a latch pulse during shifting is refused.
  assign quiet  = c_q.gs2 == c_q.gprev;
  assign cmd_ok = c_q.sh2[SHIFT_W-1 -: CMD_W] == WRITE_CMD;

  assign s_axi_awready = !c_q.aw_have && !c_q.bvalid;
  assign s_axi_wready  = !c_q.w_have && !c_q.bvalid;
  assign s_axi_arready = !c_q.rvalid;
  assign aw_hs         = s_axi_awvalid && s_axi_awready;
  assign w_hs          = s_axi_wvalid && s_axi_wready;
  assign ar_hs         = s_axi_arvalid && s_axi_arready;

  always_comb begin
    c_d       = c_q;
    c_d.gs1   = l_q.gray;
    c_d.gs2   = c_q.gs1;
    c_d.gprev = c_q.gs2;
    c_d.sh1   = l_q.shift;
    c_d.sh2   = c_q.sh1;
    if (latch_pulse && quiet && cmd_ok) begin
      c_d.latch = c_q.sh2[LATCH_W-1:0];
    end
    if (c_q.en) begin
      c_d.cnt = c_q.cnt + 16'h1;
    end
    for (int i = 0; i < CH_N; i++) begin
      c_d.pwm[i] = !c_q.latch[BLANK_BIT] &&
                   ({1'b0, c_q.cnt[POS_W-1:0]} <
                    on_len(c_q.latch[i*GRAY_W +: GRAY_W], c_q.cnt[CNT_W-1 -: PER_W]));
    end
    if (aw_hs) begin
      c_d.aw_have = 1'b1;
      c_d.awaddr  = s_axi_awaddr;
    end
    if (w_hs) begin
      c_d.w_have = 1'b1;
      c_d.wdata  = s_axi_wdata;
      c_d.wstrb  = s_axi_wstrb;
    end
    if (c_q.bvalid && s_axi_bready) begin
      c_d.bvalid = 1'b0;
    end
    if (c_q.aw_have && c_q.w_have) begin
      c_d.aw_have = 1'b0;
      c_d.w_have  = 1'b0;
      c_d.bvalid  = 1'b1;
      c_d.bresp   = RESP_OKAY;
      case (c_q.awaddr)
        CTRL_OFF: begin
          if (c_q.wstrb[0]) begin
            c_d.en = c_q.wdata[CTRL_EN_BIT];
          end
        end
        STATUS_OFF: begin
          c_d.bresp = RESP_OKAY;
        end
        default: begin
          c_d.bresp = RESP_SLVERR;
        end
      endcase
    end
    if (c_q.rvalid && s_axi_rready) begin
      c_d.rvalid = 1'b0;
    end
    if (ar_hs) begin
      c_d.rvalid = 1'b1;
      c_d.rdata  = '0;
      c_d.rresp  = RESP_OKAY;
      case (s_axi_araddr)
        CTRL_OFF: begin
          c_d.rdata[CTRL_EN_BIT] = c_q.en;
        end
        STATUS_OFF: begin
          c_d.rdata[STAT_BLANK_BIT] = c_q.latch[BLANK_BIT];
          c_d.rdata[STAT_QUIET_BIT] = quiet;
          c_d.rdata[STAT_PER_LSB +: PER_W] = c_q.cnt[CNT_W-1 -: PER_W];
        end
        default: begin
          c_d.rresp = RESP_SLVERR;
        end
      endcase
    end
    if (!aresetn) begin
      c_d.latch[BLANK_BIT] = 1'b1;
      c_d.cnt     = CNT_RESET;
      c_d.pwm     = '0;
      c_d.en      = CTRL_EN_RESET;
      c_d.aw_have = 1'b0;
      c_d.awaddr  = '0;
      c_d.w_have  = 1'b0;
      c_d.wdata   = '0;
      c_d.wstrb   = '0;
      c_d.bvalid  = 1'b0;
      c_d.bresp   = RESP_OKAY;
      c_d.rvalid  = 1'b0;
      c_d.rdata   = '0;
      c_d.rresp   = RESP_OKAY;
    end
  end

  always_ff @(posedge aclk) begin
    c_q <= c_d;
  end

  assign s_axi_bvalid           = c_q.bvalid;
  assign s_axi_bresp            = c_q.bresp;
  assign s_axi_rvalid           = c_q.rvalid;
  assign s_axi_rdata            = c_q.rdata;
  assign s_axi_rresp            = c_q.rresp;
  assign pwm_out                = c_q.pwm;
  assign color_group_brightness = c_q.latch[BC_LSB +: BC_W];
  assign function_settings      = c_q.latch[FC_LSB +: FC_W];

  // Each channel carries its own gray value, so every row is watched on the
  // channel that holds that value rather than on channel zero alone.
  sequence s_ch(int ch, logic [GRAY_W-1:0] g, logic [CNT_W-1:0] c);
    c_q.en && !c_q.latch[BLANK_BIT] && !latch_pulse &&
    c_q.latch[ch*GRAY_W +: GRAY_W] == g && c_q.cnt == c;
  endsequence

  sequence s_last_on(int ch);
    pwm_out[ch] ##1 !pwm_out[ch];
  endsequence

  property p_latch_copy;
    @(posedge aclk) disable iff (!aresetn)
    latch_pulse && quiet && cmd_ok |=> c_q.latch == $past(c_q.sh2[LATCH_W-1:0]);
  endproperty
  a_latch_copy: assert property (p_latch_copy) else $error("latch not copied");

  property p_latch_keep;
    @(posedge aclk) disable iff (!aresetn)
    latch_pulse && !cmd_ok |=> c_q.latch === $past(c_q.latch);
  endproperty
  a_latch_keep: assert property (p_latch_keep) else $error("latch changed on bad command");

  property p_latch_only_pulse;
    @(posedge aclk) disable iff (!aresetn)
    !latch_pulse |=> c_q.latch === $past(c_q.latch);
  endproperty
  a_latch_only_pulse: assert property (p_latch_only_pulse) else $error("latch moved");

  property p_shift;
    @(posedge serial_shift_clock) disable iff (!l_q.rst2)
    1'b1 |=> l_q.shift === {$past(l_q.shift[SHIFT_W-2:0]), $past(serial_in_pin)};
  endproperty
  a_shift: assert property (p_shift) else $error("shift wrong");

  property p_sout;
    @(posedge serial_shift_clock) disable iff (!l_q.rst2)
    1'b1 |=> serial_out_pin === $past(l_q.shift[SHIFT_W-2]);
  endproperty
  a_sout: assert property (p_sout) else $error("serial out wrong");

  property p_reset_blank;
    @(posedge aclk) !aresetn |=> c_q.latch[BLANK_BIT] && pwm_out == '0;
  endproperty
  a_reset_blank: assert property (p_reset_blank) else $error("blank not set");

  property p_blank_off;
    @(posedge aclk) disable iff (!aresetn)
    c_q.latch[BLANK_BIT] |=> pwm_out == '0;
  endproperty
  a_blank_off: assert property (p_blank_off) else $error("output on while blanked");

  property p_ffff;
    @(posedge aclk) disable iff (!aresetn)
    s_ch(0, 16'hffff, 16'hfffe) |=> s_last_on(0);
  endproperty
  a_ffff: assert property (p_ffff) else $error("ffff last period wrong");

  property p_fffe;
    @(posedge aclk) disable iff (!aresetn)
    s_ch(1, 16'hfffe, 16'h7ffe) |=> s_last_on(1);
  endproperty
  a_fffe: assert property (p_fffe) else $error("fffe period 64 wrong");

  property p_ff01;
    @(posedge aclk) disable iff (!aresetn)
    s_ch(2, 16'hff01, 16'h01ff) |=> pwm_out[2];
  endproperty
  a_ff01: assert property (p_ff01) else $error("ff01 first period wrong");

  property p_ff00;
    @(posedge aclk) disable iff (!aresetn)
    s_ch(3, 16'hff00, 16'h01fe) |=> s_last_on(3);
  endproperty
  a_ff00: assert property (p_ff00) else $error("ff00 wrong");

  property p_feff;
    @(posedge aclk) disable iff (!aresetn)
    s_ch(4, 16'hfeff, 16'hfffd) |=> s_last_on(4);
  endproperty
  a_feff: assert property (p_feff) else $error("feff last period wrong");

  property p_order;
    @(posedge aclk) disable iff (!aresetn)
    s_ch(5, 16'h0006, 16'h8000) |=> pwm_out[5];
  endproperty
  a_order: assert property (p_order) else $error("period 65 not on");

  property p_wr_resp;
    @(posedge aclk) disable iff (!aresetn)
    aw_hs && w_hs |=> ##1 s_axi_bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("no write response");

  property p_rd_resp;
    @(posedge aclk) disable iff (!aresetn)
    ar_hs |=> s_axi_rvalid;
  endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("no read response");

  property p_b_hold;
    @(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");

  property p_r_hold;
    @(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read response dropped");

  property p_aw_block;
    @(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_aw_block: assert property (p_aw_block) else $error("write taken during response");

  property p_gray_zero;
    @(posedge aclk) disable iff (!aresetn)
    !latch_pulse && c_q.latch[10*GRAY_W +: GRAY_W] == 16'h0 |=> !pwm_out[10];
  endproperty
  a_gray_zero: assert property (p_gray_zero) else $error("zero gray output on");

  property p_cnt_step;
    @(posedge aclk) disable iff (!aresetn)
    c_q.en |=> c_q.cnt == $past(c_q.cnt) + 16'h1;
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("counter did not step");

  property p_cnt_hold;
    @(posedge aclk) disable iff (!aresetn)
    !c_q.en |=> $stable(c_q.cnt);
  endproperty
  a_cnt_hold: assert property (p_cnt_hold) else $error("counter moved while off");

  property p_ffff_first;
    @(posedge aclk) disable iff (!aresetn)
    s_ch(0, 16'hffff, 16'h01fe) |=> pwm_out[0] ##1 pwm_out[0];
  endproperty
  a_ffff_first: assert property (p_ffff_first) else $error("ffff first period short");

  property p_fffe_first;
    @(posedge aclk) disable iff (!aresetn)
    s_ch(1, 16'hfffe, 16'h01fe) |=> pwm_out[1] ##1 pwm_out[1];
  endproperty
  a_fffe_first: assert property (p_fffe_first) else $error("fffe first period short");

  property p_ff01_next;
    @(posedge aclk) disable iff (!aresetn)
    s_ch(2, 16'hff01, 16'h03fe) |=> s_last_on(2);
  endproperty
  a_ff01_next: assert property (p_ff01_next) else $error("ff01 second period wrong");

  property p_ff00_next;
    @(posedge aclk) disable iff (!aresetn)
    s_ch(3, 16'hff00, 16'h03fe) |=> s_last_on(3);
  endproperty
  a_ff00_next: assert property (p_ff00_next) else $error("ff00 second period wrong");

  property p_feff_first;
    @(posedge aclk) disable iff (!aresetn)
    s_ch(4, 16'hfeff, 16'h01fe) |=> s_last_on(4);
  endproperty
  a_feff_first: assert property (p_feff_first) else $error("feff first period wrong");

  property p_split;
    @(posedge aclk) disable iff (!aresetn)
    s_ch(6, 16'h0081, 16'h0001) |=> pwm_out[6] ##1 !pwm_out[6];
  endproperty
  a_split: assert property (p_split) else $error("extra clock misplaced");
endmodule
`default_nettype wire

/* File: verification/lgs_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module lgs_host_model (
  output logic serial_shift_clock,
  output logic serial_in_pin
);
  initial begin
    serial_shift_clock = 1'h0;
    serial_in_pin      = 1'h0;
  end
  // The clock stands still between frames, and the idle data line flips so a stale bit never looks valid.
  task automatic send(input logic [223:0] f, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      serial_in_pin = f[i];
      #15 serial_shift_clock = 1'h1;
      #15 serial_shift_clock = 1'h0;
    end
    serial_in_pin = ~serial_in_pin;
  endtask
endmodule
`default_nettype wire

/* File: verification/led_gray_shift_latch_pwm_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module led_gray_shift_latch_pwm_tb;
  import lgs_pkg::*;
  logic        aclk, aresetn, awv, wv, bry, arv, rry, lp, awr, wr, bv, arr, rv, sck, sin, sout;
  logic [1:0]  bresp, rresp;
  logic [3:0]  awa, ara;
  logic [31:0] wd, rd;
  logic [11:0] pwm;
  logic [20:0] bc;
  logic [4:0]  fc;
  logic [11:0] samp [65536];
  int          on_n [12][128];
  int          n_fail = 0;
  int          checks_done = 0;
  logic [15:0] gray_tab [12] = '{16'hffff, 16'hfffe, 16'hff01, 16'hff00, 16'hfeff, 16'h0006,
                                 16'h0081, 16'h00ff, 16'h0100, 16'h007f, 16'h0000, 16'h0001};

  lgs_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rry), .serial_shift_clock(sck),
    .serial_in_pin(sin), .serial_out_pin(sout), .latch_pulse(lp), .pwm_out(pwm),
    .color_group_brightness(bc), .function_settings(fc));
  lgs_host_model host_u (.serial_shift_clock(sck), .serial_in_pin(sin));

  initial begin
    aclk = 1'h0;
    forever #25 aclk = ~aclk;
  end

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tmo();
    n_fail++;
    finish_test();
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge aclk);
    awa <= a;
    wd  <= d;
    awv <= 1'h1;
    wv  <= 1'h1;
    bry <= 1'h1;
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (awr === 1'h1) awv <= 1'h0;
      if (wr === 1'h1) wv <= 1'h0;
      if (bv === 1'h1) break;
    end
    r = bresp;
    bry <= 1'h0;
    if (i == 100) tmo();
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge aclk);
    ara <= a;
    arv <= 1'h1;
    rry <= 1'h1;
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (arr === 1'h1) arv <= 1'h0;
      if (rv === 1'h1) break;
    end
    d = rd;
    r = rresp;
    rry <= 1'h0;
    if (i == 100) tmo();
  endtask

  // The gap before the pulse lets the link data clear both synchroniser stages.
  task automatic pulse();
    repeat (8) @(posedge aclk);
    lp <= 1'h1;
    @(posedge aclk);
    lp <= 1'h0;
    repeat (3) @(posedge aclk);
  endtask

  function automatic logic [223:0] frm(logic [5:0] c, logic b, logic [20:0] br);
    logic [223:0] f;
    f = {c, 4'h5, b, br, 192'h0};
    for (int k = 0; k < 12; k++) f[16*k +: 16] = gray_tab[k];
    return f;
  endfunction

  function automatic int exp_on(logic [15:0] g, int p);
    logic [6:0] rv7;
    int         base;
    for (int k = 0; k < 7; k++) rv7[k] = p[6-k];
    base = int'(g[15:7]) + int'(rv7 < g[6:0]);
    if (g[15:7] == ADJ_LO || g[15:7] == ADJ_HI) base++;
    return base;
  endfunction

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    int          m;
    aresetn = 1'h0;
    {awv, wv, bry, arv, rry, lp} = 6'h0;
    {awa, ara, wd} = 40'h0;
    fork
      host_u.send('0, 4);
      repeat (4) @(posedge aclk);
    join
    aresetn <= 1'h1;
    @(posedge aclk);
    chk(pwm, 12'h0);
    chk(fc[0], 1'h1);
    axi_rd(CTRL_OFF, d, r);
    chk(d[0], CTRL_EN_RESET);
    axi_rd(STATUS_OFF, d, r);
    chk(d[1:0], 2'h3);
    axi_rd(4'h8, d, r);
    chk(d, 32'h0);
    chk(r, RESP_SLVERR);
    axi_wr(4'hc, 32'h0, r);
    chk(r, RESP_SLVERR);
    host_u.send(frm(6'h1a, 1'h0, 21'h0), 224);
    chk(sout, 1'h0);
    pulse();
    chk(fc[0], 1'h1);
    host_u.send(frm(WRITE_CMD, 1'h1, 21'h1abcde), 224);
    chk(sout, 1'h1);
    pulse();
    chk(bc, 21'h1abcde);
    chk(fc, 5'h0b);
    chk(pwm, 12'h0);
    host_u.send(frm(WRITE_CMD, 1'h0, 21'h1abcde), 224);
    pulse();
    chk(fc, 5'h0a);
    for (int k = 0; k < 65536; k++) begin
      @(negedge aclk);
      samp[k] = pwm;
    end
    m = -1;
    for (int k = 0; k < 65536; k++) if (samp[k][11] === 1'h1 && m < 0) m = k;
    if (m < 0) tmo();
    for (int k = 0; k < 65536; k++)
      for (int c = 0; c < 12; c++) on_n[c][((k - m) & 65535) >> 9] += int'(samp[k][c] === 1'h1);
    for (int c = 0; c < 12; c++)
      for (int p = 0; p < 128; p++)
        chk(on_n[c][p], exp_on(gray_tab[c], p));
    host_u.send(frm(WRITE_CMD, 1'h0, 21'h05a5a5), 224);
    repeat (8) @(posedge aclk);
    chk(bc, 21'h1abcde);
    pulse();
    chk(bc, 21'h05a5a5);
    axi_rd(STATUS_OFF, d, r);
    chk(d[0], 1'h0);
    axi_wr(CTRL_OFF, 32'h0, r);
    chk(r, RESP_OKAY);
    axi_rd(CTRL_OFF, d, r);
    chk(d[0], 1'h0);
    repeat (4) @(posedge aclk);
    finish_test();
  end
endmodule
`default_nettype wire
